// [design/sa_pkg.sv]
// Shared constants, codes and carrier types for the sampling converter sequencer
package sa_pkg;

  // Register port offsets
  localparam logic [2:0] SA_OFS_CTRL   = 3'h0; // converter_control_reg
  localparam logic [2:0] SA_OFS_CFG    = 3'h1; // converter_config_reg
  localparam logic [2:0] SA_OFS_ACC    = 3'h2; // accumulator_config_reg
  localparam logic [2:0] SA_OFS_RESH   = 3'h3; // result_high_byte
  localparam logic [2:0] SA_OFS_RESL   = 3'h4; // result_low_byte
  localparam logic [2:0] SA_OFS_DCDC   = 3'h5; // dcdc_config_reg

  // Control register fields
  localparam int SA_CTRL_MODE_LSB = 0;  // start_mode_field [2:0]
  localparam int SA_CTRL_BUSY     = 3;  // conversion_busy_bit
  localparam int SA_CTRL_EOC      = 4;  // end_of_conversion_flag
  localparam int SA_CTRL_IRQEN    = 5;  // end-of-conversion interrupt enable
  localparam int SA_CTRL_BURST    = 6;  // burst_mode_enable
  // Config register field
  localparam int SA_CFG_DIV_LSB   = 3;  // clock_divider_field [7:3]
  // Accumulator config fields
  localparam int SA_ACC_RPT_LSB   = 0;  // repeat_count_field [2:0]
  localparam int SA_ACC_FMT_LSB   = 3;  // result_format_field [5:3]
  // Dc-dc config fields
  localparam int SA_DCDC_SYNC     = 0;  // synchronise starts to converter
  localparam int SA_DCDC_INV      = 1;  // sync_clock_invert_bit

  // Reset values
  localparam logic [7:0] SA_CTRL_RST = 8'h00;
  localparam logic [7:0] SA_CFG_RST  = 8'hF8;
  localparam logic [7:0] SA_ACC_RST  = 8'h00;
  localparam logic [7:0] SA_DCDC_RST = 8'h00;

  // Start-mode codes
  localparam logic [2:0] SA_CM_SOFT = 3'h0;
  localparam logic [2:0] SA_CM_TMR0 = 3'h1;
  localparam logic [2:0] SA_CM_TMR2 = 3'h2;
  localparam logic [2:0] SA_CM_TMR3 = 3'h3;
  localparam logic [2:0] SA_CM_EXT  = 3'h4;
  localparam logic [2:0] SA_CM_TMR1 = 3'h5;

  // Format codes
  localparam logic [2:0] SA_FMT_RIGHT = 3'h0;
  localparam logic [2:0] SA_FMT_LEFT  = 3'h4;

  // Sync hold-off: one converter clock period at its slowest
  localparam int SA_CLK_NS       = 10;
  localparam int SA_SYNC_MAX_NS  = 625;
  localparam int SA_SYNC_MAX_CYC = SA_SYNC_MAX_NS / SA_CLK_NS;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sa_sfr_req_t;

  // Timer overflow strobes
  typedef struct packed {
    logic t0Ovf;
    logic t1Ovf;
    logic t2LowOvf;
    logic t2HighOvf;
    logic t2Mode16;
    logic t3LowOvf;
    logic t3HighOvf;
    logic t3Mode16;
  } sa_timer_t;

endpackage : sa_pkg

// [design/sa_clk_div.sv]
// Conversion clock divider: one tick every (divide+1) source ticks
`timescale 1ns/1ps
module sa_clk_div #(
  parameter int DIV_W = 5
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             srcTick,  // One source edge seen
  input  wire logic [DIV_W-1:0] divide,   // Divide by value plus one
  output logic                  divTick   // Divided tick, registered
);

  logic [DIV_W-1:0] count;  // Source edges since last tick

  // Count source edges, wrap at the divide value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count   <= '0;
      divTick <= 1'b0;
    end else begin
      divTick <= 1'b0;
      if (srcTick) begin
        if (count >= divide) begin
          count   <= '0;
          divTick <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule : sa_clk_div

// [design/sa_sequencer.sv]
// Converter start sequencer, sample accumulator and result formatter
//
// How it works
// RULE1 - Single sample right-justified, upper bits zero
// RULE2 - Format 100 left-justifies ten bits
// RULE3 - Series summed, result written after last
// RULE4 - Repeat field picks 1,4,8,16,32,64 samples
// RULE5 - Software keeps right format when repeating
// RULE6 - Format shifts accumulator right one-three
// RULE7 - Conversion clock from system or oscillator
// RULE8 - Start mode selects one of trigger sources
// RULE9 - Busy high during conversion, cleared after
// RULE10 - Busy fall sets flag, raises interrupt; code sets the flag only when the last sample of a series arrives
// RULE11 - Software polls the flag, not busy
// RULE12 - Timer 2/3 overflow byte follows width
// RULE13 - Software makes crossbar skip the start pin
// RULE14 - Sync mode waits for converter sync
// RULE15 - Sync mode clocks from converter, divide one
// RULE16 - Invert bit flips converter clock polarity
// RULE17 - Software clears sync in two-cell mode
// RULE18 - Flag set only after full repeat count
// RULE19 - Start mode 100 uses external input
// RULE20 - Triggers ignored while series in progress
`timescale 1ns/1ps
module sa_sequencer
  import sa_pkg::*;
#(
  parameter int CODE_W = 10,  // Converter code width
  parameter int ACC_W  = 16   // Accumulator width
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire sa_sfr_req_t       sfrReq,      // Register port request
  output logic [7:0]             sfrRdata,    // Read data, one cycle later
  input  wire sa_timer_t         timers,      // Timer overflow strobes
  input  wire logic              extStart,    // external_start_input level
  input  wire logic              lpOscClk,    // Low-power oscillator level
  input  wire logic              dcdcClk,     // Dc-dc converter clock level
  input  wire logic              dcdcSync,    // Dc-dc quiet-phase sync level
  input  wire logic              sarDone,     // Analog conversion finished
  input  wire logic [CODE_W-1:0] sarCode,     // Code with sarDone
  output logic                   sarStart,    // Start pulse to analog core
  output logic                   convClkTick, // Conversion clock tick
  output logic                   busy,        // Busy bit mirror
  output logic                   eocIrq       // Interrupt request level
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and state

  typedef enum logic [1:0] {SA_IDLE, SA_SYNC, SA_START, SA_CONV} sa_state_t;

  sa_state_t        state;      // Sequencer state
  logic [2:0]       startMode;  // start_mode_field
  logic             eocFlag;    // end_of_conversion_flag
  logic             irqEn;      // Interrupt enable
  logic             burst_mode_enable;    // burst_mode_enable
  logic [4:0]       clkDiv;     // clock_divider_field
  logic [2:0]       rptCode;    // repeat_count_field
  logic [2:0]       fmtCode;    // result_format_field
  logic             syncEn;     // Dc-dc synchronisation
  logic             clkInv;     // sync_clock_invert_bit
  logic [ACC_W-1:0] acc;        // Running sum
  logic [ACC_W-1:0] result;     // Formatted result pair
  logic [6:0]       doneCnt;    // Samples taken in this series
  logic [6:0]       syncWait;   // Cycles spent waiting for sync
  logic             extPrev;    // External start, last cycle
  logic             lpPrev;     // Oscillator, last cycle
  logic             dcPrev;     // Converter clock, last cycle
  logic             syncPrev;   // Sync, last cycle

  logic             wrCtrl;     // Control register write
  logic             trigger;    // Selected start event
  logic             syncEdge;   // Rising sync edge
  logic             srcTick;    // Selected clock source edge
  logic [6:0]       rptTarget;  // Samples per series
  logic             lastDone;   // Final sample of series arrives
  logic [ACC_W-1:0] sumNext;    // Sum including current code
  logic [ACC_W-1:0] next_result; // Formatted sum

  assign wrCtrl = sfrReq.wr && (sfrReq.addr == SA_OFS_CTRL);

  ////////////////////////////////////////////////////////////////////////
  // Trigger selection

  // Edge history for pins sampled on clk
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      extPrev  <= 1'b0;
      lpPrev   <= 1'b0;
      dcPrev   <= 1'b0;
      syncPrev <= 1'b0;
    end else begin
      extPrev  <= extStart;
      lpPrev   <= lpOscClk;
      dcPrev   <= dcdcClk;
      syncPrev <= dcdcSync;
    end
  end

  assign syncEdge = dcdcSync && !syncPrev;

  // Pick the start event for the programmed mode
  always_comb begin
    unique case (startMode)
      SA_CM_SOFT: trigger = wrCtrl && sfrReq.wdata[SA_CTRL_BUSY];      // RULE8
      SA_CM_TMR0: trigger = timers.t0Ovf;                              // RULE8
      SA_CM_TMR1: trigger = timers.t1Ovf;
      // Timer width decides which byte overflow counts
      SA_CM_TMR2: trigger = timers.t2Mode16 ? timers.t2HighOvf
                                            : timers.t2LowOvf;         // RULE12
      SA_CM_TMR3: trigger = timers.t3Mode16 ? timers.t3HighOvf
                                            : timers.t3LowOvf;         // RULE12
      SA_CM_EXT:  trigger = extStart && !extPrev;                      // RULE19
      default:    trigger = 1'b0;  // Codes 110 and 111 start nothing
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion clock source and divider

  // Burst uses the oscillator, sync mode the converter clock
  always_comb begin
    if (syncEn) begin
      // Inverted clock counts falling edges instead
      srcTick = clkInv ? (!dcdcClk && dcPrev) : (dcdcClk && !dcPrev); // RULE15 RULE16
    end else if (burst_mode_enable) begin
      srcTick = lpOscClk && !lpPrev;                                  // RULE7
    end else begin
      srcTick = 1'b1;                                                 // RULE7
    end
  end

  // Software sets divide 00000 in sync mode, so every edge ticks
  sa_clk_div #(.DIV_W(5)) u_div (
    .clk     (clk),
    .rst_n   (rst_n),
    .srcTick (srcTick),
    .divide  (clkDiv),
    .divTick (convClkTick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Series bookkeeping

  // Repeat code to sample count; spare codes fall back to one
  always_comb begin
    unique case (rptCode)
      3'h1:    rptTarget = 7'h04;  // RULE4
      3'h2:    rptTarget = 7'h08;
      3'h3:    rptTarget = 7'h10;
      3'h4:    rptTarget = 7'h20;
      3'h5:    rptTarget = 7'h40;
      default: rptTarget = 7'h01;
    endcase
  end

  assign sumNext  = acc + ACC_W'(sarCode);                             // RULE3
  assign lastDone = (state == SA_CONV) && sarDone && (doneCnt + 7'h01 >= rptTarget);

  // Formatting; left form assumes a single sample (software keeps it so)
  always_comb begin
    unique case (fmtCode)
      3'h0:    next_result = sumNext;                                  // RULE1
      3'h1:    next_result = sumNext >> 1;                             // RULE6
      3'h2:    next_result = sumNext >> 2;                             // RULE6
      3'h3:    next_result = sumNext >> 3;                             // RULE6
      default: next_result = {sumNext[CODE_W-1:0], (ACC_W-CODE_W)'(0)}; // RULE2
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Triggers outside idle fall through unanswered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= SA_IDLE;
      syncWait <= '0;
    end else begin
      unique case (state)
        SA_IDLE: begin
          if (trigger) begin
            state    <= syncEn ? SA_SYNC : SA_START;                   // RULE14
            syncWait <= '0;
          end
        end
        SA_SYNC: begin
          // Converter sync comes within one period; timeout guards a stall
          syncWait <= syncWait + 7'h01;
          if (syncEdge || syncWait >= 7'(SA_SYNC_MAX_CYC)) begin
            state <= SA_START;                                         // RULE14
          end
        end
        SA_START: state <= SA_CONV;
        SA_CONV: begin
          if (sarDone) begin
            if (lastDone || !burst_mode_enable) begin
              state <= SA_IDLE;                                        // RULE9
            end else begin
              state    <= syncEn ? SA_SYNC : SA_START;
              syncWait <= '0;
            end
          end
        end
      endcase
    end
  end

  // Start pulse, busy mirror
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sarStart <= 1'b0;
      busy     <= 1'b0;
    end else begin
      sarStart <= (state == SA_START);
      // Busy follows the next state so it falls with completion
      busy     <= (state == SA_IDLE) ? trigger
                : !((state == SA_CONV) && sarDone && (lastDone || !burst_mode_enable)); // RULE9 RULE20
    end
  end

  // Accumulator, sample count, result update at series end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc     <= '0;
      doneCnt <= '0;
      result  <= '0;
    end else if ((state == SA_CONV) && sarDone) begin
      if (lastDone) begin
        acc     <= '0;
        doneCnt <= '0;
        result  <= next_result;                                        // RULE3
      end else begin
        acc     <= sumNext;                                            // RULE3
        doneCnt <= doneCnt + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port

  // Control fields; a series end beats a software clear of the flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      startMode <= SA_CTRL_RST[SA_CTRL_MODE_LSB +: 3];
      irqEn     <= SA_CTRL_RST[SA_CTRL_IRQEN];
      burst_mode_enable   <= SA_CTRL_RST[SA_CTRL_BURST];
      eocFlag   <= SA_CTRL_RST[SA_CTRL_EOC];
    end else begin
      if (wrCtrl) begin
        startMode <= sfrReq.wdata[SA_CTRL_MODE_LSB +: 3];
        irqEn     <= sfrReq.wdata[SA_CTRL_IRQEN];
        burst_mode_enable   <= sfrReq.wdata[SA_CTRL_BURST];
        eocFlag   <= sfrReq.wdata[SA_CTRL_EOC];
      end
      if (lastDone) begin
        eocFlag <= 1'b1;                                               // RULE10 RULE18
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clkDiv  <= SA_CFG_RST[SA_CFG_DIV_LSB +: 5];
      rptCode <= SA_ACC_RST[SA_ACC_RPT_LSB +: 3];
      fmtCode <= SA_ACC_RST[SA_ACC_FMT_LSB +: 3];
      syncEn  <= SA_DCDC_RST[SA_DCDC_SYNC];
      clkInv  <= SA_DCDC_RST[SA_DCDC_INV];
    end else if (sfrReq.wr) begin
      if (sfrReq.addr == SA_OFS_CFG) clkDiv <= sfrReq.wdata[SA_CFG_DIV_LSB +: 5];
      if (sfrReq.addr == SA_OFS_ACC) begin
        rptCode <= sfrReq.wdata[SA_ACC_RPT_LSB +: 3];
        fmtCode <= sfrReq.wdata[SA_ACC_FMT_LSB +: 3];
      end
      if (sfrReq.addr == SA_OFS_DCDC) begin
        syncEn <= sfrReq.wdata[SA_DCDC_SYNC];
        clkInv <= sfrReq.wdata[SA_DCDC_INV];
      end
    end
  end

  // Read data and interrupt output, both registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfrRdata <= 8'h00;
      eocIrq   <= 1'b0;
    end else begin
      eocIrq <= eocFlag && irqEn;                                      // RULE10
      if (sfrReq.rd) begin
        unique case (sfrReq.addr)
          SA_OFS_CTRL: sfrRdata <= {1'b0, burst_mode_enable, irqEn, eocFlag, busy, startMode};
          SA_OFS_CFG:  sfrRdata <= {clkDiv, 3'h0};
          SA_OFS_ACC:  sfrRdata <= {2'h0, fmtCode, rptCode};
          SA_OFS_RESH: sfrRdata <= result[15:8];
          SA_OFS_RESL: sfrRdata <= result[7:0];
          SA_OFS_DCDC: sfrRdata <= {6'h00, clkInv, syncEn};
          default:     sfrRdata <= 8'h00;
        endcase
      end else begin
        sfrRdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence seqFinal;
    (state == SA_CONV) && sarDone && lastDone;
  endsequence

  sequence seqSoftKick;
    (state == SA_IDLE) && (startMode == SA_CM_SOFT) && wrCtrl
      && sfrReq.wdata[SA_CTRL_BUSY] && !syncEn;
  endsequence

  busy_ignore_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE20
    (state == SA_CONV) && !sarDone |=> busy && (state != SA_IDLE))
    else $error("Series left conversion without a done");

  eoc_set_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
    seqFinal |=> eocFlag && !busy)
    else $error("Flag not set after final sample");

  eoc_early_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
    !eocFlag && !lastDone && !wrCtrl |=> !eocFlag)
    else $error("Flag set before series ended");

  right_fmt_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    seqFinal and ((rptCode == 3'h0) && (fmtCode == SA_FMT_RIGHT) && (acc == '0))
      |=> result == {6'h00, $past(sarCode)})
    else $error("Right-justified result wrong");

  left_fmt_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    seqFinal and ((rptCode == 3'h0) && (fmtCode == SA_FMT_LEFT))
      |=> result[5:0] == 6'h00 && result[15:6] == $past(sarCode))
    else $error("Left-justified result wrong");

  acc_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    (state == SA_CONV) && sarDone && !lastDone |=> $stable(result))
    else $error("Result changed mid-series");

  shift_fmt_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    seqFinal and (fmtCode == 3'h2) |=> result == (($past(acc) + $past(sarCode)) >> 2))
    else $error("Shifted result wrong");

  soft_start_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    seqSoftKick |=> busy ##1 sarStart)
    else $error("Software start did not launch");

  busy_fall_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    (state == SA_CONV) && sarDone && !burst_mode_enable |=> !busy && state == SA_IDLE)
    else $error("Busy held after completion");

  irq_out_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    seqFinal and (irqEn && !wrCtrl) |=> ##1 eocIrq)
    else $error("Interrupt not raised");

  sync_wait_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
    (state == SA_IDLE) && trigger && syncEn |=> (state == SA_SYNC) && !sarStart)
    else $error("Sync mode started without waiting");

  tmr2_sel_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    (state == SA_IDLE) && (startMode == SA_CM_TMR2) && timers.t2Mode16
      && !timers.t2HighOvf |=> state == SA_IDLE)
    else $error("Timer 2 low byte started a 16-bit series");

endmodule : sa_sequencer

// [tb/sa_far_model.sv]
// Far-side model: timer strobes, external start pin and analog core
`timescale 1ns/1ps
module sa_far_model
  import sa_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sarStart,
  output logic            sarDone,
  output logic [9:0]      sarCode,
  output sa_timer_t       timers,
  output logic            extStart
);
  logic [9:0] code;   // Code the next conversion returns
  int         lat;    // Cycles from start to done
  int         starts; // Start pulses seen so far

  // Quiet idle levels
  initial begin
    code = 10'h000;
    lat = 4;
    starts = 0;
    sarDone = 1'b0;
    sarCode = 10'h3FF;
    timers = '0;
    extStart = 1'b0;
  end

  ////////////////////////////////////////
  // Analog core: answer each start; code line shows junk outside done
  always @(posedge clk) begin
    if (sarStart === 1'b1) begin
      starts <= starts + 1;
      fork
        begin
          repeat (lat) @(posedge clk);
          #1 sarDone = 1'b1;
          sarCode = code;
          @(posedge clk);
          #1 sarDone = 1'b0;
          sarCode = ~code;
        end
      join_none
    end
  end

  // One-cycle overflow strobe; hold keeps the width bits
  task automatic pulse(input logic [7:0] bits, input logic [7:0] hold);
    @(posedge clk);
    #1 timers = bits | hold;
    @(posedge clk);
    #1 timers = hold;
  endtask : pulse

  // Rising edge on the start pin, held two cycles; pin kept off the crossbar
  task automatic extEdge();
    @(posedge clk);
    #1 extStart = 1'b1;
    repeat (2) @(posedge clk);
    #1 extStart = 1'b0;
  endtask : extEdge
endmodule : sa_far_model

// [tb/testbench.sv]
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module testbench
  import sa_pkg::*;
;
  logic        clk;
  logic        rst_n;
  sa_sfr_req_t sfrReq;
  logic [7:0]  sfrRdata;
  sa_timer_t   timers;
  logic        extStart, lpOscClk, dcdcClk, dcdcSync;
  logic        sarDone, sarStart, convClkTick, busy, eocIrq;
  logic [9:0]  sarCode;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [7:0]  q;
  logic [15:0] res;
  int          cnt [6] = '{1, 4, 8, 16, 32, 64};

  sa_sequencer dut (.clk(clk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
    .timers(timers), .extStart(extStart), .lpOscClk(lpOscClk), .dcdcClk(dcdcClk),
    .dcdcSync(dcdcSync), .sarDone(sarDone), .sarCode(sarCode), .sarStart(sarStart),
    .convClkTick(convClkTick), .busy(busy), .eocIrq(eocIrq));
  sa_far_model far (.clk(clk), .sarStart(sarStart), .sarDone(sarDone), .sarCode(sarCode),
    .timers(timers), .extStart(extStart));

  ////////////////////////////////////////
  // Clock, oscillator at a quarter rate, hang guard
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always begin
    repeat (2) @(posedge clk);
    #1 lpOscClk = ~lpOscClk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      summarize();
    end
  end

  ////////////////////////////////////////
  // Shared steps; every drive lands 1 ns after the edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // One register access, then an idle cycle so strobes never merge
  task automatic sfr(input logic w, input logic [2:0] a, input logic [7:0] d);
    sfrReq = '{addr: a, wr: w, rd: !w, wdata: d};
    tick();
    sfrReq = '0;
    q = sfrRdata;
    tick();
  endtask : sfr
  task automatic result();
    sfr(1'b0, SA_OFS_RESH, 8'h00);
    res[15:8] = q;
    sfr(1'b0, SA_OFS_RESL, 8'h00);
    res[7:0] = q;
  endtask : result
  task automatic waitIdle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      tick();
      n++;
    end
    check({15'h0000, busy}, 16'h0000, "busy cleared");
  endtask : waitIdle
  task automatic countTicks(input int n, output int c);
    c = 0;
    repeat (n) begin
      tick();
      if (convClkTick === 1'b1) c++;
    end
  endtask : countTicks

  ////////////////////////////////////////
  // Scenarios
  task automatic resetValues();
    logic [7:0] exp [8] = '{SA_CTRL_RST, SA_CFG_RST, SA_ACC_RST, 8'h00, 8'h00, SA_DCDC_RST,
                            8'h00, 8'h00};
    sfr(1'b1, 3'h6, 8'hFF);
    sfr(1'b1, SA_OFS_RESH, 8'hAA);
    for (int a = 0; a < 8; a++) begin
      sfr(1'b0, 3'(a), 8'h00);
      check({8'h00, q}, {8'h00, exp[a]}, "reset value");
    end
  endtask : resetValues
  // Soft start of one series, busy polled, flag and result compared
  task automatic softRun(input logic [7:0] acc, input logic [7:0] ctl, input logic [9:0] code,
                         input logic [15:0] exp);
    far.code = code;
    sfr(1'b1, SA_OFS_ACC, acc);
    sfr(1'b1, SA_OFS_CTRL, ctl | 8'h08);
    check({15'h0000, busy}, 16'h0001, "busy during series");
    waitIdle();
    sfr(1'b0, SA_OFS_CTRL, 8'h00);
    check({8'h00, q & 8'h18}, 16'h0010, "flag after series");
    check({15'h0000, eocIrq}, {15'h0000, ctl[5]}, "irq request");
    result();
    check(res, exp, "result");
  endtask : softRun
  // Without burst each sample needs its own start
  task automatic nonBurst();
    far.code = 10'h100;
    sfr(1'b1, SA_OFS_ACC, 8'h01);
    for (int i = 0; i < 4; i++) begin
      sfr(1'b1, SA_OFS_CTRL, 8'h08);
      waitIdle();
      sfr(1'b0, SA_OFS_CTRL, 8'h00);
      check({8'h00, q & 8'h10}, {8'h00, i == 3 ? 8'h10 : 8'h00}, "flag per sample");
    end
    result();
    check(res, 16'h0400, "non-burst sum");
  endtask : nonBurst
  // Other source must not start; selected one starts once (right 0 means pin)
  task automatic trigger(input logic [2:0] mode, input logic [7:0] hold,
                         input logic [7:0] wrong, input logic [7:0] right);
    int s;
    sfr(1'b1, SA_OFS_ACC, 8'h00);
    sfr(1'b1, SA_OFS_CTRL, {5'h00, mode});
    s = far.starts;
    far.pulse(wrong, hold);
    repeat (4) tick();
    check(16'(far.starts - s), 16'h0000, "other source");
    if (right == 8'h00) far.extEdge();
    else far.pulse(right, hold);
    repeat (4) tick();
    check(16'(far.starts - s), 16'h0001, "selected source");
    waitIdle();
  endtask : trigger
  task automatic ignoreBusy();
    int s;
    far.lat = 30;
    s = far.starts;
    // Soft mode first, so the first kick really starts a series
    sfr(1'b1, SA_OFS_CTRL, 8'h00);
    sfr(1'b1, SA_OFS_CTRL, 8'h08);
    sfr(1'b1, SA_OFS_CTRL, 8'h08);
    check({15'h0000, busy}, 16'h0001, "busy held");
    waitIdle();
    check(16'(far.starts - s), 16'h0001, "one start only");
    far.lat = 4;
  endtask : ignoreBusy
  task automatic syncHold();
    int s;
    s = far.starts;
    sfr(1'b1, SA_OFS_DCDC, 8'h01);
    sfr(1'b1, SA_OFS_CFG, 8'h00);
    sfr(1'b1, SA_OFS_CTRL, 8'h08);
    repeat (20) tick();
    check(16'(far.starts - s), 16'h0000, "held for sync");
    dcdcSync = 1'b1;
    repeat (4) tick();
    check(16'(far.starts - s), 16'h0001, "released by sync");
    dcdcSync = 1'b0;
    waitIdle();
  endtask : syncHold
  task automatic clockSource();
    int c;
    sfr(1'b1, SA_OFS_DCDC, 8'h00);
    sfr(1'b1, SA_OFS_CTRL, 8'h00);
    sfr(1'b1, SA_OFS_CFG, 8'h18);
    countTicks(80, c);
    check(16'(c), 16'h0014, "system clock by four");
    sfr(1'b1, SA_OFS_CFG, 8'h00);
    sfr(1'b1, SA_OFS_CTRL, 8'h40);
    countTicks(80, c);
    check(16'(c), 16'h0014, "oscillator by one");
  endtask : clockSource
  // Ticks follow the converter clock edge picked by the invert bit
  task automatic syncClock(input logic inv);
    int up;
    int dn;
    int c;
    up = 0;
    dn = 0;
    sfr(1'b1, SA_OFS_CTRL, 8'h00);
    sfr(1'b1, SA_OFS_DCDC, {6'h00, inv, 1'b1});
    repeat (4) begin
      dcdcClk = 1'b1;
      countTicks(10, c);
      up += c;
      dcdcClk = 1'b0;
      countTicks(10, c);
      dn += c;
    end
    check(16'(up), inv ? 16'h0000 : 16'h0004, "ticks after rise");
    check(16'(dn), inv ? 16'h0004 : 16'h0000, "ticks after fall");
  endtask : syncClock

  task automatic summarize();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    sfrReq = '0;
    lpOscClk = 1'b0;
    dcdcClk = 1'b0;
    dcdcSync = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    resetValues();
    softRun(8'h00, 8'h20, 10'h3FF, 16'h03FF);
    softRun(8'h20, 8'h00, 10'h3FF, 16'hFFC0);
    softRun(8'h20, 8'h00, 10'h200, 16'h8000);
    for (int r = 0; r < 6; r++) begin
      softRun(8'(r), 8'h40, 10'h3FF, 16'(1023 * cnt[r]));
    end
    softRun(8'h09, 8'h40, 10'h3FF, 16'h07FE);
    softRun(8'h13, 8'h40, 10'h3FF, 16'h0FFC);
    softRun(8'h1D, 8'h40, 10'h3FF, 16'h1FF8);
    nonBurst();
    trigger(SA_CM_TMR0, 8'h00, 8'h40, 8'h80);
    trigger(SA_CM_TMR2, 8'h00, 8'h10, 8'h20);
    trigger(SA_CM_TMR2, 8'h08, 8'h20, 8'h10);
    trigger(SA_CM_TMR3, 8'h00, 8'h02, 8'h04);
    trigger(SA_CM_TMR3, 8'h01, 8'h04, 8'h02);
    trigger(SA_CM_EXT, 8'h00, 8'h80, 8'h00);
    trigger(SA_CM_TMR1, 8'h00, 8'h80, 8'h40);
    ignoreBusy();
    syncHold();
    clockSource();
    syncClock(1'b0);
    syncClock(1'b1);
    summarize();
  end
endmodule : testbench
